/* File: logic/mirq_regs.svh */
// register offsets, reset values and field constants for the irq unit
`ifndef MIRQ_REGS_SVH
`define MIRQ_REGS_SVH

// byte offsets on the wishbone slave, one aligned word each
`define MIRQ_OFS_VECTOR 8'h00
`define MIRQ_OFS_STATUS_LOW 8'h04
`define MIRQ_OFS_STATUS_MID 8'h08
`define MIRQ_OFS_STATUS_HIGH 8'h0c
`define MIRQ_OFS_ENABLE_LOW 8'h10
`define MIRQ_OFS_ENABLE_MID 8'h14
`define MIRQ_OFS_ENABLE_HIGH 8'h18
`define MIRQ_OFS_NEST_CTRL 8'h1c

// reset values
`define MIRQ_ENABLE_RST 16'hffff
// vector base: line 0 maps to 10h
`define MIRQ_VECTOR_BASE 8'h10
// number of request lines including the unused line 0
`define MIRQ_LINES 48
// lines with no source attached
`define MIRQ_RESERVED_MASK 48'h0000_0020_4015
// nest control field: bit 0 is the global maskable enable
`define MIRQ_NEST_EN_BIT 0

`endif

/* File: logic/mirq_pkg.sv */
// types shared by the irq unit files
package mirq_pkg;

  // one wishbone classic request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } mirq_wb_req_t;

  // core handshake state
  typedef enum logic [1:0] {
    MIRQ_IDLE,
    MIRQ_WAIT_ACK,
    MIRQ_IN_HANDLER
  } mirq_state_t;

endpackage : mirq_pkg

/* File: logic/mirq_prio_enc.sv */
// linear fixed priority encoder, highest index wins
`timescale 1ns/1ps
module mirq_prio_enc #(
  parameter int WIDTH = 48
) (
  // request vector
  input wire logic [WIDTH-1:0] req,
  // result
  output logic any,
  output logic [5:0] index
);

  // elaboration check: the index port holds six bits only
  if (WIDTH < 2 || WIDTH > 64)
  begin : g_bad_width
    $error("mirq_prio_enc: width out of range");
  end

  // scan upward so the highest set bit is the last write
  always_comb
  begin
    any = 1'b0;
    index = 6'h00;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (req[i])
      begin
        any = 1'b1;
        index = 6'(i);
      end
    end
  end

endmodule : mirq_prio_enc

/* File: logic/mirq_unit.sv */
// maskable interrupt unit: enables, status, priority and vector
`timescale 1ns/1ps
`include "mirq_regs.svh"

// What this block does
// - enable register for lines 16-31, resets ffff
// - enable register for lines 32-47, resets ffff
// - status register shows lines 16-31 live
// - status register shows lines 32-47 live
// - status ignores enable bits
// - status bit 0 of low register reads zero
// - enable one lets request compete; zero blocks
// - status one while source requests
// - linear priority, line 47 highest
// - fixed source per line, reserved lines unused
// - non-maskable interrupt always preempts, no enable
// - maskable entry blocks further until global enable
// - no hardware limit on nesting depth
// - up to 47 level inputs, vectored request out
// - vector is 10h plus winning line
// - vector reports highest asserted and enabled
// - enable register for lines 1-15, resets ffff
module mirq_unit (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // peripheral request lines, level, asynchronous
  input wire logic [47:0] irq_line,
  // non-maskable request pin, asynchronous, active high
  input wire logic nmi_req,
  // core side
  output logic irq_req,
  output logic nmi_take,
  output logic [7:0] irq_vector,
  input wire logic irq_ack,
  input wire logic handler_done
);

  // bundled bus request
  mirq_pkg::mirq_wb_req_t bus;
  assign bus = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                 sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

  // two-stage synchroniser for request lines
  logic [47:0] line_meta;
  logic [47:0] line_sync;
  // nmi synchroniser and edge history
  logic nmi_meta;
  logic nmi_sync;
  logic nmi_prev;
  // enable registers
  logic [15:0] irq_enable_low;
  logic [15:0] irq_enable_mid;
  logic [15:0] irq_enable_high;
  // global maskable enable, processor status bit image
  logic global_en;
  // nesting depth counter; handler_done returns the handshake to idle only at depth 1
  logic [15:0] nest_depth;
  // gated request vector and encoder result
  logic [47:0] live;
  logic [47:0] armed;
  logic win_any;
  logic [5:0] win_idx;
  // core handshake state
  mirq_pkg::mirq_state_t state;
  // bus decode
  logic bus_hit;
  logic [31:0] next_rdata;
  logic known_adr;

  // synchronise asynchronous inputs before any logic reads them
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      line_meta <= 48'h0;
      line_sync <= 48'h0;
    end
    else
    begin
      line_meta <= irq_line;
      line_sync <= line_meta;
    end
  end

  // nmi pin synchroniser
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      nmi_meta <= 1'b0;
      nmi_sync <= 1'b0;
      nmi_prev <= 1'b0;
    end
    else
    begin
      nmi_meta <= nmi_req;
      nmi_sync <= nmi_meta;
      nmi_prev <= nmi_sync;
    end
  end

  // reserved lines tied off, line 0 has no source
  assign live = line_sync & ~`MIRQ_RESERVED_MASK;

  // enable gating; bit 0 of the low enable is ignored
  assign armed = live & {irq_enable_high, irq_enable_mid,
                         irq_enable_low[15:1], 1'b0};

  // highest armed line wins
  mirq_prio_enc #(
    .WIDTH(`MIRQ_LINES)
  ) u_prio (
    .req(armed),
    .any(win_any),
    .index(win_idx)
  );

  // vector register, updated every cycle so it always tracks the winner
  // the core reads it at the ack edge, a cycle after irq_req, so it settled
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      irq_vector <= `MIRQ_VECTOR_BASE;
    end
    else if (win_any)
    begin
      irq_vector <= `MIRQ_VECTOR_BASE + {2'b00, win_idx};
    end
    else
    begin
      // nothing pending reads as line 0, the error vector
      irq_vector <= `MIRQ_VECTOR_BASE;
    end
  end

  // nmi taken on rising edge, never gated by any enable
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      nmi_take <= 1'b0;
    end
    else
    begin
      nmi_take <= nmi_sync & ~nmi_prev;
    end
  end

  // maskable request to core only while globally enabled
  assign irq_req = (state == mirq_pkg::MIRQ_IDLE ||
                    state == mirq_pkg::MIRQ_IN_HANDLER) &&
                   global_en && win_any;

  // core handshake: entry blocks further maskable requests
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state <= mirq_pkg::MIRQ_IDLE;
    end
    else
    begin
      case (state)
        mirq_pkg::MIRQ_IDLE:
        begin
          if (irq_req)
          begin
            state <= mirq_pkg::MIRQ_WAIT_ACK;
          end
        end
        mirq_pkg::MIRQ_WAIT_ACK:
        begin
          // irq_req is low here, so one request is never taken twice
          if (irq_ack)
          begin
            state <= mirq_pkg::MIRQ_IN_HANDLER;
          end
        end
        mirq_pkg::MIRQ_IN_HANDLER:
        begin
          // a nested request restarts the handshake
          if (irq_req)
          begin
            state <= mirq_pkg::MIRQ_WAIT_ACK;
          end
          else if (handler_done && nest_depth == 16'h0001)
          begin
            state <= mirq_pkg::MIRQ_IDLE;
          end
        end
        default:
        begin
          state <= mirq_pkg::MIRQ_IDLE;
        end
      endcase
    end
  end

  // depth counter saturates; it never refuses a nest
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      nest_depth <= 16'h0000;
    end
    else if (state == mirq_pkg::MIRQ_WAIT_ACK && irq_ack)
    begin
      if (nest_depth != 16'hffff)
      begin
        nest_depth <= nest_depth + 16'h0001;
      end
    end
    else if (handler_done && nest_depth != 16'h0000)
    begin
      nest_depth <= nest_depth - 16'h0001;
    end
  end

  // global enable: cleared on acceptance, software sets it again
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      global_en <= 1'b0;
    end
    else if (state == mirq_pkg::MIRQ_WAIT_ACK && irq_ack)
    begin
      global_en <= 1'b0;
    end
    else if (bus_hit && bus.we && bus.sel[0] &&
             bus.adr == `MIRQ_OFS_NEST_CTRL)
    begin
      global_en <= bus.dat[`MIRQ_NEST_EN_BIT];
    end
  end

  // single-cycle ack: request taken at the edge where ack is low
  assign bus_hit = bus.cyc && bus.stb && !wb_ack_o;

  // enable register writes, byte lanes 0 and 1
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      irq_enable_low <= `MIRQ_ENABLE_RST;
      irq_enable_mid <= `MIRQ_ENABLE_RST;
      irq_enable_high <= `MIRQ_ENABLE_RST;
    end
    else if (bus_hit && bus.we)
    begin
      case (bus.adr)
        `MIRQ_OFS_ENABLE_LOW:
        begin
          // byte lanes are written independently
          if (bus.sel[0])
          begin
            irq_enable_low[7:0] <= bus.dat[7:0];
          end
          if (bus.sel[1])
          begin
            irq_enable_low[15:8] <= bus.dat[15:8];
          end
        end
        `MIRQ_OFS_ENABLE_MID:
        begin
          if (bus.sel[0])
          begin
            irq_enable_mid[7:0] <= bus.dat[7:0];
          end
          if (bus.sel[1])
          begin
            irq_enable_mid[15:8] <= bus.dat[15:8];
          end
        end
        `MIRQ_OFS_ENABLE_HIGH:
        begin
          if (bus.sel[0])
          begin
            irq_enable_high[7:0] <= bus.dat[7:0];
          end
          if (bus.sel[1])
          begin
            irq_enable_high[15:8] <= bus.dat[15:8];
          end
        end
        default:
        begin
          // status and vector are read-only: writes dropped
        end
      endcase
    end
  end

  // read mux; status shows raw lines, not gated
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    known_adr = 1'b1;
    case (bus.adr)
      `MIRQ_OFS_VECTOR: next_rdata = {24'h0, irq_vector};
      `MIRQ_OFS_STATUS_LOW:
        next_rdata = {16'h0, live[15:1], 1'b0};
      `MIRQ_OFS_STATUS_MID:
        next_rdata = {16'h0, live[31:16]};
      `MIRQ_OFS_STATUS_HIGH:
        next_rdata = {16'h0, live[47:32]};
      `MIRQ_OFS_ENABLE_LOW: next_rdata = {16'h0, irq_enable_low};
      `MIRQ_OFS_ENABLE_MID: next_rdata = {16'h0, irq_enable_mid};
      `MIRQ_OFS_ENABLE_HIGH: next_rdata = {16'h0, irq_enable_high};
      `MIRQ_OFS_NEST_CTRL: next_rdata = {31'h0, global_en};
      default: known_adr = 1'b0;
    endcase
  end

  // answer one cycle after the request, ack or err
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_hit && known_adr;
      wb_err_o <= bus_hit && !known_adr && !wb_err_o;
      wb_dat_o <= bus_hit ? next_rdata : 32'h0000_0000;
    end
  end

endmodule : mirq_unit

/* File: tb/mirq_unit_asserts.sv */
// port checker for the irq unit, bound to its top
`timescale 1ns/1ps
module mirq_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // core side
  input wire logic nmi_req,
  input wire logic irq_req,
  input wire logic nmi_take,
  input wire logic [7:0] irq_vector
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ack_timing_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o &&
    !wb_err_o) |=> (wb_ack_o || wb_err_o)) else $error("late answer");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property ((wb_ack_o || wb_err_o) |->
    $past(wb_cyc_i && wb_stb_i)) else $error("answer without request");
  dat_width_a: assert property (wb_dat_o[31:16] == 16'h0)
    else $error("upper data bits set");
  vec_range_a: assert property (irq_vector >= 8'h10 &&
    irq_vector <= 8'h3f) else $error("vector out of range");
  vec_reserved_a: assert property (!(irq_vector inside
    {8'h12, 8'h14, 8'h1e, 8'h25})) else $error("reserved line won");
  rst_vals_a: assert property ($past(sys_rst) |->
    (irq_vector == 8'h10 && !irq_req)) else $error("bad reset state");
  nmi_take_a: assert property ($rose(nmi_req) |-> ##[1:4] nmi_take)
    else $error("nmi not taken");
  nmi_pulse_a: assert property (nmi_take |=> !nmi_take)
    else $error("nmi take too long");
endmodule : mirq_chk

bind mirq_unit mirq_chk u_chk (.mclk, .sys_rst, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .wb_err_o, .nmi_req, .irq_req, .nmi_take,
  .irq_vector);

/* File: tb/mirq_core_model.sv */
// core stand-in: acknowledges requests, runs a short handler
`timescale 1ns/1ps
module mirq_core (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // unit side
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  output logic irq_ack,
  output logic handler_done,
  // observation
  output logic [7:0] got_vec,
  output logic [3:0] n_taken,
  output logic dflt_taken
);
  logic [5:0] run; // cycles left in the running handler
  logic [3:0] n_open; // handlers entered and not yet left
  // ack one edge after irq_req; vector is taken at the ack edge
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      irq_ack <= 1'b0;
      handler_done <= 1'b0;
      run <= 6'h00;
      n_open <= 4'h0;
      n_taken <= 4'h0;
      got_vec <= 8'h00;
      dflt_taken <= 1'b0;
    end
    else
    begin
      handler_done <= (run == 6'h01) && !irq_ack;
      if (irq_ack)
      begin
        irq_ack <= 1'b0;
        got_vec <= irq_vector;
        n_taken <= n_taken + 4'h1;
        n_open <= n_open + 4'h1;
        // long enough for a nested request to arrive
        run <= 6'h3f;
        // vectors of unused lines go to the default handler
        if (irq_vector inside {8'h10, 8'h12, 8'h14, 8'h1e, 8'h25})
          dflt_taken <= 1'b1;
      end
      else
      begin
        if (irq_req)
          irq_ack <= 1'b1;
        if (run == 6'h01)
        begin
          // leave this handler, resume the outer one if any
          n_open <= n_open - 4'h1;
          run <= (n_open > 4'h1) ? 6'h3f : 6'h00;
        end
        else if (run != 6'h00)
          run <= run - 6'h01;
      end
    end
  end
endmodule : mirq_core

/* File: tb/tb_mirq_unit.sv */
// bench for the irq unit: registers, status, priority, handshake
`timescale 1ns/1ps
`include "mirq_regs.svh"
module tb_mirq_unit;
  logic mclk = 1'b0, sys_rst = 1'b1, nmi_req = 1'b0;
  mirq_pkg::mirq_wb_req_t req = '0; // bus request
  logic [47:0] irq_line = '0;
  logic [31:0] wb_dat_o, rv;
  logic wb_ack_o, wb_err_o, irq_req, nmi_take, irq_ack, handler_done, er;
  logic [7:0] irq_vector, got_vec;
  logic [3:0] n_taken;
  logic dflt_taken;
  logic [3:0] wb_sel = 4'h3; // byte lanes of the next access
  int n_mismatch = 0, checks = 0;
  always #5 mclk = ~mclk;
  mirq_unit uut (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(req.cyc),
    .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_sel_i(req.sel),
    .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .irq_line(irq_line),
    .nmi_req(nmi_req), .irq_req(irq_req), .nmi_take(nmi_take),
    .irq_vector(irq_vector), .irq_ack(irq_ack),
    .handler_done(handler_done));
  mirq_core core (.mclk(mclk), .sys_rst(sys_rst), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_ack(irq_ack),
    .handler_done(handler_done), .got_vec(got_vec), .n_taken(n_taken),
    .dflt_taken(dflt_taken));
  task automatic give_verdict();
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string w, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", w, e, g);
    end
  endtask : chk
  // one classic cycle, held until ack or err is sampled
  task automatic wb(input logic we, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge mclk);
    req <= '{1'b1, 1'b1, we, wb_sel, a, d};
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_mismatch++;
      give_verdict();
    end
    rv = wb_dat_o;
    er = wb_err_o;
    req <= '0;
  endtask : wb
  task automatic rchk(input string w, input logic [7:0] a,
    input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(w, e, rv);
  endtask : rchk
  // lines settle through the sync flops and the vector register in three edges; the task waits five
  task automatic drive(input logic [47:0] v);
    irq_line <= v;
    repeat (5) @(posedge mclk);
  endtask : drive
  task automatic t_status();
    logic [47:0] e;
    wb(1'b1, `MIRQ_OFS_ENABLE_MID, 32'h0);
    drive(48'ha5a5_5a7a_ffff);
    e = irq_line & ~`MIRQ_RESERVED_MASK;
    rchk("st_low", `MIRQ_OFS_STATUS_LOW, {16'h0, e[15:0]});
    rchk("st_mid", `MIRQ_OFS_STATUS_MID, {16'h0, e[31:16]});
    wb(1'b1, `MIRQ_OFS_STATUS_HIGH, 32'h0);
    rchk("st_high", `MIRQ_OFS_STATUS_HIGH, {16'h0, e[47:32]});
    wb(1'b1, `MIRQ_OFS_ENABLE_MID, 32'hffff);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 1'b1, er);
    wb_sel = 4'h1;
    wb(1'b1, `MIRQ_OFS_ENABLE_LOW, 32'h0);
    wb_sel = 4'h3;
    rchk("en_lane", `MIRQ_OFS_ENABLE_LOW, 32'hff00);
    wb(1'b1, `MIRQ_OFS_ENABLE_LOW, 32'hffff);
    rchk("nest_rst", `MIRQ_OFS_NEST_CTRL, 32'h0);
  endtask : t_status
  task automatic t_prio();
    drive(48'h8100_0000_0020);
    rchk("vec_top", `MIRQ_OFS_VECTOR, 32'h3f);
    wb(1'b1, `MIRQ_OFS_ENABLE_HIGH, 32'h7fff);
    drive(irq_line);
    rchk("vec_gate", `MIRQ_OFS_VECTOR, 32'h38);
    wb(1'b1, `MIRQ_OFS_ENABLE_HIGH, 32'hffff);
    drive(48'h0000_0020_0020);
    rchk("vec_low", `MIRQ_OFS_VECTOR, 32'h15);
    drive(48'h0000_0020_4014);
    rchk("vec_rsv", `MIRQ_OFS_VECTOR, 32'h10);
  endtask : t_prio
  task automatic t_core();
    int n;
    drive(48'h8000_0000_0000);
    wb(1'b1, `MIRQ_OFS_NEST_CTRL, 32'h1);
    for (n = 0; n < 20 && n_taken == 4'h0; n++)
      @(posedge mclk);
    chk("core_vec", 8'h3f, got_vec);
    @(posedge mclk);
    chk("no_nest", 1'b0, irq_req);
    nmi_req <= 1'b1;
    for (n = 0; n < 8 && nmi_take !== 1'b1; n++)
      @(posedge mclk);
    chk("nmi", 1'b1, nmi_take);
    // handler keeps line 47 out, then opens nesting
    wb(1'b1, `MIRQ_OFS_ENABLE_HIGH, 32'h7fff);
    wb(1'b1, `MIRQ_OFS_NEST_CTRL, 32'h1);
    @(posedge mclk);
    chk("sel_nest", 1'b0, irq_req);
    // line 40 may nest; reserved line 21 must never win
    drive(irq_line | 48'h0100_0020_0000);
    for (n = 0; n < 20 && n_taken != 4'h2; n++)
      @(posedge mclk);
    chk("nest_vec", 8'h38, got_vec);
    chk("nest_cnt", 4'h2, n_taken);
    chk("dflt", 1'b0, dflt_taken);
  endtask : t_core
  task automatic t_reset_vals();
    rchk("en_low", `MIRQ_OFS_ENABLE_LOW, 32'hffff);
    rchk("en_mid", `MIRQ_OFS_ENABLE_MID, 32'hffff);
    rchk("en_high", `MIRQ_OFS_ENABLE_HIGH, 32'hffff);
    rchk("vec_rst", `MIRQ_OFS_VECTOR, 32'h10);
  endtask : t_reset_vals
  initial
  begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset_vals();
    t_status();
    t_prio();
    t_core();
    give_verdict();
  end
endmodule : tb_mirq_unit
